// >>> src/csl_defs.vh
/*
  Constants of the control signal linking block: register offsets,
  field positions, reset values and selector codes.
  Assumes inclusion by its bare name from the design file.
*/
`ifndef CSL_DEFS_VH
`define CSL_DEFS_VH

// ==========================================
// Register byte offsets
`define CSL_OFS_CFG 8'h00
`define CSL_OFS_ROUTE 8'h04
`define CSL_OFS_INV 8'h08
`define CSL_OFS_HOST 8'h0c
`define CSL_OFS_STATUS 8'h10
`define CSL_OFS_SIGNALS 8'h14

// ==========================================
// Configuration register fields
`define CSL_CFG_SLOT 1:0
`define CSL_CFG_STBY_MODE 2
`define CSL_CFG_STBY_PULSE 3
`define CSL_CFG_KEY_LOCK 5:4
`define CSL_CFG_PANEL 8:6
`define CSL_CFG_COUPLING 11:9
`define CSL_CFG_CTRL_TYPE 14:12
`define CSL_CFG_WIDTH 15
`define CSL_CFG_RST 15'h0010

// ==========================================
// Host control register fields
`define CSL_HOST_SIG 7:0
`define CSL_HOST_LOCAL_TGL 8

// ==========================================
// Control signal indices and source codes
`define CSL_SIG_STANDBY 0
`define CSL_SIG_MANUAL 1
`define CSL_SIG_GAIN 7
`define CSL_NSIG 8
`define CSL_SRC_LOW 4'h0
`define CSL_SRC_HIGH 4'h8
`define CSL_ROUTE_RST 32'h0000_0000
`define CSL_INV_RST 8'h00

// ==========================================
// Selector codes
`define CSL_KEY_LOCAL_ONLY 2'h0
`define CSL_KEY_FREE 2'h1
`define CSL_KEY_REMOTE_ONLY 2'h2
`define CSL_PANEL_AUTO_ONLY 3'h1
`define CSL_PANEL_MANUAL_ONLY 3'h2
`define CSL_PANEL_EDGE 3'h3
`define CSL_PANEL_EDGE_FREE 3'h4
`define CSL_SLOT_MIXED 2'h1
`define CSL_SLOT_FIVE_DI 2'h2
`define CSL_TYPE_LAST_SWITCH 3'h4

`endif

// >>> src/csl_control_link.v
/*
  Control signal linking: digital input routing and inversion, host
  combination, standby / local / manual state, with an AHB-Lite slave.
  Assumes inputs synchronous to clk_sys and keys as clean levels.
*/
// Behaviour
// - Each control signal takes one input or low; standby and gain also high.
// - Each routed signal is inverted by its own selector bit.
// - Slot selector 2 enables inputs three to seven from the module.
// - Slot selector 1 enables exactly inputs three and four.
// - Fitted module differing from slot selector raises an error flag.
// - All digital inputs are readable by the host.
// - Pulse standby input toggles a flip-flop on each rising edge.
// - Coupling modes 2 to 5 OR host signals into input signals.
// - Coupling modes 2 to 5 let the host toggle local select.
// - Coupling 2 or 4 forms standby as host OR input.
// - Coupling 3 or 5 forms standby as host AND input.
// - Coupling mode picks serial or analog setpoint and tracking source.
// - Types 0 to 4 switch variables on computer operation.
// - Types 5 and 6 never switch; local OR not standby locks host.
// - Standby mode 0: computer operation is not local AND standby.
// - LED shows standby inverted; messages are local and inverted operation.
// - Standby mode 1: standby rising edge sets local select.
// - Key selector 0 or 2 disables key, fixing local or remote.
// - Manual is key latch OR external manual; panels 3 and 4 use the key latch alone.
// - Panel 1 auto only, panel 2 manual only; external still forces.
// - Manual LED shows the active manual state.
// - Panels 3 and 4 toggle on external edge; 4 drops host lockout.
`include "csl_defs.vh"
`timescale 1ns/1ps
`default_nettype none

module csl_control_link (
  input wire clk_sys,
  input wire rst_n,
  input wire hsel,
  input wire [7:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  input wire [1:0] di_base,
  input wire [4:0] di_option,
  input wire [1:0] fitted_module,
  input wire key_local,
  input wire key_manual,
  output reg led_standby_n,
  output reg led_local,
  output reg led_manual,
  output reg standby_message_n,
  output reg computer_operation_n,
  output reg computer_operation,
  output reg manual_active,
  output reg serial_lockout,
  output reg setpoint_from_serial,
  output reg tracking_from_serial,
  output reg slot_error,
  output reg [7:0] control_out
);

  // ==========================================
  // Reset release
  reg rst_meta_q;
  reg rst_sync_q;
  wire rst_s_n;

  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end
  assign rst_s_n = rst_sync_q;

  // ==========================================
  // Register file and AHB-Lite slave
  reg [`CSL_CFG_WIDTH-1:0] cfg_q;
  reg [31:0] route_q;
  reg [7:0] inv_q;
  reg [7:0] host_sig_q;
  reg host_tgl_q;
  reg [7:0] wr_addr_q;
  reg wr_pend_q;
  reg rd_pend_q;
  reg [7:0] rd_addr_q;
  reg [31:0] rd_mux;
  wire [31:0] status_w;
  wire accept;

  // Reads take one wait state so a write just before is visible
  assign accept = hsel & hready & htrans[1];

  always @(posedge clk_sys or negedge rst_s_n)
  begin
    if (!rst_s_n)
    begin
      cfg_q <= `CSL_CFG_RST;
      route_q <= `CSL_ROUTE_RST;
      inv_q <= `CSL_INV_RST;
      host_sig_q <= 8'h00;
      host_tgl_q <= 1'b0;
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      rd_pend_q <= 1'b0;
      rd_addr_q <= 8'h00;
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else
    begin
      host_tgl_q <= 1'b0;
      if (wr_pend_q)
      begin
        case (wr_addr_q)
          `CSL_OFS_CFG: cfg_q <= hwdata[`CSL_CFG_WIDTH-1:0];
          `CSL_OFS_ROUTE: route_q <= hwdata;
          `CSL_OFS_INV: inv_q <= hwdata[7:0];
          `CSL_OFS_HOST:
          begin
            host_sig_q <= hwdata[`CSL_HOST_SIG];
            host_tgl_q <= hwdata[`CSL_HOST_LOCAL_TGL];
          end
          default: ;
        endcase
      end
      wr_pend_q <= accept & hwrite;
      wr_addr_q <= haddr;
      if (rd_pend_q)
      begin
        hrdata <= rd_mux;
        hreadyout <= 1'b1;
        rd_pend_q <= 1'b0;
      end
      else if (accept & ~hwrite)
      begin
        rd_pend_q <= 1'b1;
        rd_addr_q <= haddr;
        hreadyout <= 1'b0;
      end
    end
  end

  always @*
  begin
    case (rd_addr_q)
      `CSL_OFS_CFG: rd_mux = {17'h00000, cfg_q};
      `CSL_OFS_ROUTE: rd_mux = route_q;
      `CSL_OFS_INV: rd_mux = {24'h000000, inv_q};
      `CSL_OFS_HOST: rd_mux = {24'h000000, host_sig_q};
      `CSL_OFS_STATUS: rd_mux = status_w;
      `CSL_OFS_SIGNALS: rd_mux = {24'h000000, control_out};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // ==========================================
  // Digital inputs
  wire [1:0] slot_sel = cfg_q[`CSL_CFG_SLOT];
  wire [2:0] coupling = cfg_q[`CSL_CFG_COUPLING];
  wire [2:0] panel = cfg_q[`CSL_CFG_PANEL];
  wire [1:0] key_lock = cfg_q[`CSL_CFG_KEY_LOCK];
  wire slot_any = (slot_sel == `CSL_SLOT_MIXED) | (slot_sel == `CSL_SLOT_FIVE_DI);
  wire slot_five = slot_sel == `CSL_SLOT_FIVE_DI;
  wire [6:0] di;
  wire [7:0] routed;

  assign di[1:0] = di_base;
  assign di[3:2] = slot_any ? di_option[1:0] : 2'b00;
  assign di[6:4] = slot_five ? di_option[4:2] : 3'b000;

  genvar gi;
  generate
    for (gi = 0; gi < `CSL_NSIG; gi = gi + 1)
    begin : g_route
      wire [3:0] src = route_q[4*gi+3:4*gi];
      wire high_ok = (gi == `CSL_SIG_STANDBY) || (gi == `CSL_SIG_GAIN);
      wire pick = (src == `CSL_SRC_LOW) ? 1'b0 :
                  (src == `CSL_SRC_HIGH) ? high_ok :
                  (src < `CSL_SRC_HIGH) ? di[src[2:0] - 3'h1] : 1'b0;
      assign routed[gi] = pick ^ inv_q[gi];
    end
  endgenerate

  // ==========================================
  // Standby and coupling
  reg cb_tgl_q;
  reg local_q;
  reg manual_key_latch_q;
  wire stby_in_rise;
  wire coupled = coupling >= 3'h2;
  wire and_mode = (coupling == 3'h3) | (coupling == 3'h5);
  wire cb_di = cfg_q[`CSL_CFG_STBY_PULSE] ? cb_tgl_q : routed[`CSL_SIG_STANDBY];
  wire cb_es = host_sig_q[`CSL_SIG_STANDBY];
  reg computer_standby;
  wire lockout;
  wire rc;
  wire [7:0] combined;

  always @*
  begin
    if (!coupled)
      computer_standby = cb_di;
    else if (and_mode)
      computer_standby = cb_es & cb_di;
    else
      computer_standby = cb_es | cb_di;
  end
  assign rc = ~local_q & computer_standby;
  assign lockout = local_q | ~computer_standby;

  wire he_es_ok = ~lockout | (panel == `CSL_PANEL_EDGE_FREE);
  wire he_es = coupled & he_es_ok & host_sig_q[`CSL_SIG_MANUAL];
  wire manual_external = routed[`CSL_SIG_MANUAL] | he_es;

  assign combined[`CSL_SIG_STANDBY] = computer_standby;
  assign combined[`CSL_SIG_MANUAL] = manual_external;
  // Host inputs only count while computer operation holds
  assign combined[7:2] = routed[7:2] | ({6{coupled & rc}} & host_sig_q[7:2]);

  wire key_local_rise;
  wire key_manual_rise;
  wire cb_rise;
  wire he_rise;
  wire host_toggle = coupled & host_tgl_q;
  wire local_toggle = (key_local_rise & (key_lock == `CSL_KEY_FREE)) | host_toggle;
  wire panel_edge = (panel == `CSL_PANEL_EDGE) | (panel == `CSL_PANEL_EDGE_FREE);
  wire manual_now;

  assign manual_now = manual_key_latch_q | (~panel_edge & manual_external);

  // ==========================================
  // Edge detectors, all cleared by the released reset
  csl_rise_det u_rise_stby_in (
    .clk_sys(clk_sys),
    .rst_n(rst_s_n),
    .sig(routed[`CSL_SIG_STANDBY]),
    .rise(stby_in_rise)
  );

  csl_rise_det u_rise_key_local (
    .clk_sys(clk_sys),
    .rst_n(rst_s_n),
    .sig(key_local),
    .rise(key_local_rise)
  );

  csl_rise_det u_rise_key_manual (
    .clk_sys(clk_sys),
    .rst_n(rst_s_n),
    .sig(key_manual),
    .rise(key_manual_rise)
  );

  csl_rise_det u_rise_standby (
    .clk_sys(clk_sys),
    .rst_n(rst_s_n),
    .sig(computer_standby),
    .rise(cb_rise)
  );

  csl_rise_det u_rise_manual_ext (
    .clk_sys(clk_sys),
    .rst_n(rst_s_n),
    .sig(manual_external),
    .rise(he_rise)
  );

  // ==========================================
  // Flip-flop stages
  always @(posedge clk_sys or negedge rst_s_n)
  begin
    if (!rst_s_n)
    begin
      cb_tgl_q <= 1'b0;
      local_q <= 1'b1;
      manual_key_latch_q <= 1'b0;
    end
    else
    begin
      if (stby_in_rise)
        cb_tgl_q <= ~cb_tgl_q;
      if (key_lock == `CSL_KEY_LOCAL_ONLY)
        local_q <= 1'b1;
      else if (key_lock == `CSL_KEY_REMOTE_ONLY)
        local_q <= 1'b0;
      else if (cfg_q[`CSL_CFG_STBY_MODE] & cb_rise)
        local_q <= 1'b1;
      else if (local_toggle)
        local_q <= ~local_q;
      case (panel)
        `CSL_PANEL_AUTO_ONLY: manual_key_latch_q <= 1'b0;
        `CSL_PANEL_MANUAL_ONLY: manual_key_latch_q <= 1'b1;
        `CSL_PANEL_EDGE, `CSL_PANEL_EDGE_FREE:
        begin
          if (he_rise ^ key_manual_rise)
            manual_key_latch_q <= ~manual_key_latch_q;
        end
        default:
        begin
          if (key_manual_rise)
            manual_key_latch_q <= ~manual_key_latch_q;
        end
      endcase
    end
  end

  // ==========================================
  // Registered outputs
  always @(posedge clk_sys or negedge rst_s_n)
  begin
    if (!rst_s_n)
    begin
      led_standby_n <= 1'b1;
      led_local <= 1'b1;
      led_manual <= 1'b0;
      standby_message_n <= 1'b1;
      computer_operation_n <= 1'b1;
      computer_operation <= 1'b0;
      manual_active <= 1'b0;
      serial_lockout <= 1'b1;
      setpoint_from_serial <= 1'b0;
      tracking_from_serial <= 1'b0;
      slot_error <= 1'b0;
      control_out <= 8'h00;
    end
    else
    begin
      led_standby_n <= ~computer_standby;
      led_local <= local_q;
      led_manual <= manual_now;
      standby_message_n <= local_q;
      computer_operation_n <= ~rc;
      computer_operation <= rc & (cfg_q[`CSL_CFG_CTRL_TYPE] <= `CSL_TYPE_LAST_SWITCH);
      manual_active <= manual_now;
      serial_lockout <= lockout;
      setpoint_from_serial <= (coupling == 3'h2) | (coupling == 3'h3);
      tracking_from_serial <= (coupling == 3'h2) | (coupling == 3'h3);
      slot_error <= fitted_module != slot_sel;
      control_out <= combined;
    end
  end

  // Input states and block state for the host
  assign status_w = {16'h0000, slot_error, manual_now, rc, local_q,
                     computer_standby, lockout, 3'b000, di};

endmodule // csl_control_link

// ==========================================
// Rising edge detector
module csl_rise_det (
  input wire clk_sys,
  input wire rst_n,
  input wire sig,
  output wire rise
);

  // Cleared low so an input idling low gives no false edge after reset
  reg prev_q;

  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      prev_q <= 1'b0;
    else
      prev_q <= sig;
  end

  assign rise = sig & ~prev_q;

endmodule // csl_rise_det

`default_nettype wire

// >>> verification/csl_control_link_properties.sv
/* Checker of the linking block outputs.
   Assumes a bind onto csl_control_link. */
`timescale 1ns/1ps
`default_nettype none
// ======
// Checker
module csl_props (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic led_standby_n,
  input wire logic led_local,
  input wire logic led_manual,
  input wire logic standby_message_n,
  input wire logic computer_operation_n,
  input wire logic computer_operation,
  input wire logic manual_active,
  input wire logic serial_lockout,
  input wire logic setpoint_from_serial,
  input wire logic tracking_from_serial,
  input wire logic [7:0] control_out
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  AST_LED_STBY: assert property (led_standby_n == !control_out[0])
    else $error("standby led");
  AST_MSG_LOCAL: assert property (standby_message_n == led_local)
    else $error("standby message");
  AST_OP_N: assert property (computer_operation_n == (led_local || led_standby_n))
    else $error("operation message");
  AST_LOCKOUT: assert property (serial_lockout == (led_local || led_standby_n))
    else $error("lockout");
  AST_OP: assert property (computer_operation |-> !computer_operation_n)
    else $error("operation");
  AST_MAN_LED: assert property (manual_active == led_manual)
    else $error("manual led");
  AST_SRC: assert property (setpoint_from_serial == tracking_from_serial)
    else $error("source select");
  AST_RD_WAIT: assert property (hsel && hready && htrans[1] && !hwrite
    |=> !hreadyout ##1 hreadyout)
    else $error("read wait");
  AST_RESP_OKAY: assert property (!hresp)
    else $error("response not okay");
endmodule // csl_props

bind csl_control_link csl_props u_props (.clk_sys, .rst_n, .hsel, .htrans, .hwrite,
  .hready, .hreadyout, .hresp, .led_standby_n, .led_local, .led_manual, .standby_message_n,
  .computer_operation_n, .computer_operation, .manual_active, .serial_lockout,
  .setpoint_from_serial, .tracking_from_serial, .control_out);
`default_nettype wire

// >>> verification/csl_host_model.sv
/* Host computer model: single-word AHB-Lite master.
   Assumes hready is the slave's hreadyout. */
`timescale 1ns/1ps
`default_nettype none
// ======
// Host master
module csl_host_model (
  input wire logic clk_sys,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  output logic hsel,
  output logic [7:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata,
  output logic [31:0] rd_data,
  output int rd_cnt,
  output logic hang
);
  initial
  begin
    {hsel, haddr, htrans, hwrite, hwdata, rd_data, hang} = '0;
    hsize = 3'h2;
    rd_cnt = 0;
  end
  // Bounded, so a dead slave ends the run
  task automatic wait_rdy;
    int n;
    begin
      n = 0;
      @(posedge clk_sys);
      while (!hready && n <= 50)
      begin
        n++;
        @(posedge clk_sys);
      end
      // The bench ends the run once hang rises
      if (!hready)
        hang <= 1'b1;
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    if (!w)
    begin
      rd_data <= hrdata;
      rd_cnt <= rd_cnt + 1;
    end
  endtask
endmodule // csl_host_model
`default_nettype wire

// >>> verification/tb_top.sv
/* Self-checking bench of the control signal linking block.
   Assumes the host model owns the register bus. */
`timescale 1ns/1ps
`default_nettype none
// ======
// Bench
module tb_top;
  localparam logic [31:0] ALL = 32'hffff_ffff;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [1:0] di_base = 2'h0;
  logic [4:0] di_option = 5'h0;
  logic [1:0] fitted_module = 2'h0;
  logic key_local = 1'b0;
  logic key_manual = 1'b0;
  logic hsel, hwrite, hready, hang, computer_operation, setpoint_from_serial, slot_error;
  logic led_manual;
  logic [7:0] haddr;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata, rd_data, r;
  logic [31:0] seed = 32'h0000_7367;
  logic [31:0] exp_q[$], msk_q[$];
  logic [2:0] mp [8] = '{3'h1, 3'h1, 3'h2, 3'h1, 3'h3, 3'h3, 3'h3, 3'h3};
  logic [7:0] md = 8'h52;
  logic [7:0] me = 8'h36;
  int rd_cnt, failures = 0, checked = 0;
  csl_control_link uut (.clk_sys, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready(hready), .hrdata, .hreadyout(hready), .hresp(), .di_base,
    .di_option, .fitted_module, .key_local, .key_manual, .led_standby_n(),
    .led_local(), .led_manual, .standby_message_n(), .computer_operation_n(),
    .computer_operation, .manual_active(), .serial_lockout(), .setpoint_from_serial,
    .tracking_from_serial(), .slot_error, .control_out());
  csl_host_model host (.clk_sys, .hready, .hrdata, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hwdata, .rd_data, .rd_cnt, .hang);
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [31:0] cfg(logic [1:0] s, logic m, logic p, logic [1:0] k,
    logic [2:0] pn, logic [2:0] c, logic [2:0] t);
    return {17'h0, t, c, pn, k, p, m, s};
  endfunction
  task automatic cmp(input logic ok);
    checked++;
    if (ok !== 1'b1)
    begin
      failures++;
      $display("[FAIL] %0t mismatch", $time);
    end
  endtask
  task automatic report_and_stop;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic st;
    repeat (4) @(posedge clk_sys);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    host.xfer(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    exp_q.push_back(e);
    msk_q.push_back(m);
    host.xfer(1'b0, a, ~e);
  endtask
  // Edge on key local, key manual, or both base inputs
  task automatic pulse(input int w);
    if (w == 0) key_local <= 1'b1; else if (w == 1) key_manual <= 1'b1; else di_base <= 2'h3;
    st();
    if (w == 0) key_local <= 1'b0; else if (w == 1) key_manual <= 1'b0; else di_base <= 2'h0;
    st();
  endtask
  always @(rd_cnt)
    if (exp_q.size() > 0)
      cmp(((rd_data ^ exp_q.pop_front()) & msk_q.pop_front()) === 32'h0);
  always @(posedge hang)
  begin
    failures++;
    report_and_stop();
  end
  initial
  begin
    forever #10 clk_sys = ~clk_sys;
  end
  initial
  begin
    repeat (16) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
    rd(8'h00, 32'h0000_0010, ALL);
    rd(8'h04, 32'h0, ALL);
    wr(8'h1c, ALL);
    rd(8'h1c, 32'h0, ALL);
    wr(8'h04, 32'h0000_0021);
    wr(8'h00, cfg(0, 0, 1, 1, 0, 0, 0));
    pulse(2);
    rd(8'h10, 32'h0000_0800, 32'h0000_0800);
    pulse(2);
    rd(8'h10, 32'h0, 32'h0000_0800);
    $display("reset and pulse test done");
    for (int s = 0; s < 3; s++)
    begin
      r = xs();
      {di_option, di_base} <= r[6:0];
      fitted_module <= s[1:0];
      wr(8'h00, cfg(s[1:0], 0, 0, 1, 0, 0, 0));
      st();
      rd(8'h10, {25'h0, r[6:0] & (s == 2 ? 7'h7f : s == 1 ? 7'h0f : 7'h03)}, 32'h807f);
      fitted_module <= s[1:0] + 2'h1;
      st();
      cmp(slot_error === 1'b1);
    end
    for (int k = 0; k < 10; k++)
    begin
      r = xs();
      {di_option, di_base} <= r[6:0];
      wr(8'h04, {20'h0, k[3:0], 8'h88});
      wr(8'h08, {29'h0, r[9:7]});
      st();
      rd(8'h14, {29'h0, ((k > 0 && k < 8) ? r[k - 1] : 1'b0) ^ r[9], r[8], !r[7]}, 32'h7);
    end
    $display("slot and routing test done");
    fitted_module <= 2'h0;
    di_base <= 2'h0;
    wr(8'h04, 32'h0000_0021);
    wr(8'h08, 32'h0);
    wr(8'h00, cfg(0, 0, 0, 1, 0, 0, 0));
    st();
    rd(8'h10, 32'h0000_1400, 32'h0000_3c00);
    pulse(0);
    di_base <= 2'h1;
    st();
    rd(8'h10, 32'h0000_2800, 32'h0000_3c00);
    cmp(computer_operation === 1'b1);
    wr(8'h00, cfg(0, 0, 0, 1, 0, 0, 5));
    st();
    cmp(computer_operation === 1'b0);
    di_base <= 2'h0;
    wr(8'h00, cfg(0, 1, 0, 1, 0, 0, 0));
    st();
    di_base <= 2'h1;
    st();
    rd(8'h10, 32'h0000_1c00, 32'h0000_3c00);
    pulse(0);
    rd(8'h10, 32'h0000_2800, 32'h0000_3c00);
    wr(8'h00, cfg(0, 0, 0, 0, 0, 2, 0));
    wr(8'h00, cfg(0, 0, 0, 1, 0, 2, 0));
    wr(8'h0c, 32'h0000_0105);
    st();
    rd(8'h10, 32'h0, 32'h0000_1000);
    rd(8'h14, 32'h4, 32'h4);
    wr(8'h00, cfg(0, 0, 0, 1, 0, 0, 0));
    wr(8'h0c, 32'h0000_0100);
    st();
    rd(8'h10, 32'h0, 32'h0000_1000);
    for (int k = 0; k < 3; k += 2)
    begin
      wr(8'h00, cfg(0, 0, 0, k[1:0], 0, 0, 0));
      pulse(0);
      rd(8'h10, {19'h0, k == 0, 12'h0}, 32'h0000_1000);
    end
    $display("local select test done");
    for (int i = 0; i < 8; i++)
    begin
      wr(8'h00, cfg(0, 0, 0, 1, 0, i[2] ? 3'h3 : 3'h2, 0));
      wr(8'h0c, {31'h0, i[1]});
      di_base <= {1'b0, i[0]};
      st();
      rd(8'h10, {20'h0, i[2] ? i[1] & i[0] : i[1] | i[0], 11'h0}, 32'h800);
    end
    for (int c = 0; c < 6; c++)
    begin
      wr(8'h00, cfg(0, 0, 0, 1, 0, c[2:0], 0));
      st();
      cmp(setpoint_from_serial === (c == 2 || c == 3));
    end
    $display("coupling test done");
    di_base <= 2'h0;
    wr(8'h00, cfg(0, 0, 0, 1, 0, 0, 0));
    pulse(1);
    rd(8'h10, 32'h0000_4000, 32'h0000_4000);
    for (int i = 0; i < 8; i++)
    begin
      wr(8'h00, cfg(0, 0, 0, 1, mp[i], 0, 0));
      di_base <= {md[i], 1'b0};
      st();
      rd(8'h10, {17'h0, me[i], 14'h0}, 32'h0000_4000);
      cmp(led_manual === me[i]);
    end
    wr(8'h00, cfg(0, 0, 0, 0, 0, 2, 0));
    wr(8'h0c, 32'h0000_0002);
    st();
    rd(8'h14, 32'h0, 32'h2);
    wr(8'h00, cfg(0, 0, 0, 0, 4, 2, 0));
    st();
    rd(8'h14, 32'h2, 32'h2);
    $display("manual test done");
    st();
    report_and_stop();
  end
endmodule // tb_top
`default_nettype wire
